// ==== design/dag_defines.svh ====
// Constants of the dual address generator block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef DAG_DEFINES_SVH
`define DAG_DEFINES_SVH

// ****************************************************************
// Register map, one aligned word each
// ****************************************************************
// Pointer n of generator g at PTR_BASE + 0x40*g + 4*n
`define DAG_PTR_BASE 12'h000
`define DAG_MOD_BASE 12'h010
`define DAG_LEN_BASE 12'h020
`define DAG_GEN_STRIDE 12'h040
`define DAG_CTRL_ADDR 12'h080
`define DAG_PX_ADDR 12'h084
`define DAG_CTRL_BREV_BIT 0
`define DAG_RESP_OKAY 2'h0
`define DAG_RESP_SLVERR 2'h2
`define DAG_ADDR_W 14
`define DAG_PM_W 24
`define DAG_DM_W 16
`define DAG_PX_W 8

`endif

// ==== design/dag_pkg.sv ====
// Types shared by the address generator block.
// Assumes dag_defines.svh on the include path.
`include "dag_defines.svh"
package dag_pkg;
  // One indirect access request per generator
  typedef struct packed {
    logic valid;
    logic [1:0] ptr_sel;
    logic [1:0] mod_sel;
  } dag_req_s;
  // Program memory data transfer through the extension register
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`DAG_DM_W-1:0] wdata;
    logic [`DAG_PM_W-1:0] rdata;
  } dag_pmx_s;
endpackage : dag_pkg

// ==== design/dag_top.sv ====
// Two data address generators with pointer, modify and length banks,
// circular wrap, bit-reversed first generator data address and the program memory extension byte.
// Assumes the sequencer issues requests on core_clk_i; registers over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "dag_defines.svh"
module dag_top #(
  parameter int AW = `DAG_ADDR_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Sequencer requests
  input wire dag_pkg::dag_req_s data_req_i,
  input wire dag_pkg::dag_req_s dual_req_i,
  input wire logic dual_to_pm_i,
  // Addresses
  output logic [AW-1:0] data_memory_address_o,
  output logic data_memory_address_valid_o,
  output logic [AW-1:0] program_memory_address_bus_o,
  output logic program_memory_address_valid_o,
  // Extension path
  input wire dag_pkg::dag_pmx_s pmx_i,
  output logic [`DAG_PM_W-1:0] program_memory_data_bus_o,
  output logic [`DAG_DM_W-1:0] data_memory_data_bus_o,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Pointers travel as 16-bit data words, so wider ones cannot be loaded
  if (AW < 2 || AW > 16) begin : g_aw_check
    $error("dag_top: AW out of range");
  end

  // ****************************************************************
  // Register banks, index [generator*4 + n]
  // ****************************************************************
  logic [AW-1:0] ptr_q [8];
  logic [AW-1:0] mod_q [8];
  logic [AW-1:0] len_q [8];
  logic brev_q;
  logic [`DAG_PX_W-1:0] px_q;

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  logic [11:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic w_held_q;
  logic wr_fire;
  logic wr_hit;
  logic [2:0] wr_idx;
  logic [1:0] wr_bank;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_fire = aw_held_q && w_held_q;
  // Strobes ignored: every field is narrower than a word
  assign wr_idx = {awaddr_q[6], awaddr_q[3:2]};
  assign wr_bank = awaddr_q[5:4];

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
    end
  end

  // Holes in each bank answer with an error
  always_comb begin
    wr_hit = 1'b0;
    if (awaddr_q[11:7] == 5'h00 && awaddr_q[5:4] != 2'h3) begin
      wr_hit = 1'b1;
    end
    if (awaddr_q == `DAG_CTRL_ADDR || awaddr_q == `DAG_PX_ADDR) begin
      wr_hit = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DAG_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `DAG_RESP_OKAY : `DAG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Address generation
  // ****************************************************************
  function automatic logic [AW-1:0] bit_rev(input logic [AW-1:0] a);
    logic [AW-1:0] r;
    r = '0;
    for (int i = 0; i < AW; i++) begin
      r[i] = a[AW-1-i];
    end
    return r;
  endfunction : bit_rev

  // Base is the pointer rounded down to a multiple of the length
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p, input logic [AW-1:0] m,
                                             input logic [AW-1:0] l);
    logic [AW:0] off;
    logic [AW-1:0] base;
    logic [AW:0] sum;
    off = '0;
    base = '0;
    sum = '0;
    if (l == '0) begin
      return AW'(p + m);
    end
    off = {1'b0, p % l};
    base = AW'(p - off[AW-1:0]);
    if (m[AW-1]) begin
      sum = off - {1'b0, AW'(-m)};
      if (sum[AW]) begin
        sum = sum + {1'b0, l};
      end
    end else begin
      sum = off + {1'b0, m};
      if (sum >= {1'b0, l}) begin
        sum = sum - {1'b0, l};
      end
    end
    return AW'(base + sum[AW-1:0]);
  endfunction : next_ptr

  logic [2:0] d_idx;
  logic [2:0] d_midx;
  logic [2:0] s_idx;
  logic [2:0] s_midx;
  assign d_idx = {1'b0, data_req_i.ptr_sel};
  assign d_midx = {1'b0, data_req_i.mod_sel};
  assign s_idx = {1'b1, dual_req_i.ptr_sel};
  assign s_midx = {1'b1, dual_req_i.mod_sel};

  for (genvar g = 0; g < 8; g++) begin : g_bank
    logic use_ptr;
    logic [2:0] midx;
    assign use_ptr = (g < 4) ? (data_req_i.valid && d_idx == 3'(g)) : (dual_req_i.valid && s_idx == 3'(g));
    assign midx = (g < 4) ? d_midx : s_midx;
    always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
        ptr_q[g] <= '0;
        mod_q[g] <= '0;
        len_q[g] <= '0;
      end else begin
        // Sequencer access wins over a same-cycle pointer write; modify and length writes still land
        // post modify pointer
        if (use_ptr) begin
          ptr_q[g] <= next_ptr(ptr_q[g], mod_q[midx], len_q[g]);
        end else if (wr_fire && wr_hit && wr_idx == 3'(g) && wr_bank == 2'h0) begin
          ptr_q[g] <= wdata_q[AW-1:0];
        end
        if (wr_fire && wr_hit && wr_idx == 3'(g) && wr_bank == 2'h1) begin
          mod_q[g] <= wdata_q[AW-1:0];
        end
        if (wr_fire && wr_hit && wr_idx == 3'(g) && wr_bank == 2'h2) begin
          len_q[g] <= wdata_q[AW-1:0];
        end
      end
    end
  end

  // both addresses in one cycle
  // First generator owns the data bus; a clashing dual address is dropped
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      data_memory_address_o <= '0;
      data_memory_address_valid_o <= 1'b0;
    end else begin
      data_memory_address_valid_o <= 1'b0;
      // first generator data memory, optional reversal
      if (data_req_i.valid) begin
        data_memory_address_o <= brev_q ? bit_rev(ptr_q[d_idx]) : ptr_q[d_idx];
        data_memory_address_valid_o <= 1'b1;
      end else if (dual_req_i.valid && !dual_to_pm_i) begin
        data_memory_address_o <= ptr_q[s_idx];
        data_memory_address_valid_o <= 1'b1;
      end
    end
  end

  // second generator either space, never reversed
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      program_memory_address_bus_o <= '0;
      program_memory_address_valid_o <= 1'b0;
    end else begin
      program_memory_address_valid_o <= 1'b0;
      if (dual_req_i.valid && dual_to_pm_i) begin
        program_memory_address_bus_o <= ptr_q[s_idx];
        program_memory_address_valid_o <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Program memory extension byte
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      px_q <= '0;
      program_memory_data_bus_o <= '0;
      data_memory_data_bus_o <= '0;
    end else begin
      if (pmx_i.rd) begin
        px_q <= pmx_i.rdata[`DAG_PX_W-1:0];
        data_memory_data_bus_o <= pmx_i.rdata[`DAG_PM_W-1:`DAG_PX_W];
      end else if (wr_fire && awaddr_q == `DAG_PX_ADDR) begin
        px_q <= wdata_q[`DAG_PX_W-1:0];
      end
      if (pmx_i.wr) begin
        program_memory_data_bus_o <= {pmx_i.wdata, px_q};
      end
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  // reversal enable set by software only
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      brev_q <= 1'b0;
    end else if (wr_fire && awaddr_q == `DAG_CTRL_ADDR) begin
      brev_q <= wdata_q[`DAG_CTRL_BREV_BIT];
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  logic [2:0] rd_idx;
  assign rd_idx = {s_axi_araddr[6], s_axi_araddr[3:2]};
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DAG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DAG_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr == `DAG_CTRL_ADDR) begin
        s_axi_rdata <= {31'h0000_0000, brev_q};
      end else if (s_axi_araddr == `DAG_PX_ADDR) begin
        s_axi_rdata <= {24'h00_0000, px_q};
      end else if (s_axi_araddr[11:7] == 5'h00 && s_axi_araddr[5:4] == 2'h0) begin
        s_axi_rdata <= 32'(ptr_q[rd_idx]);
      end else if (s_axi_araddr[11:7] == 5'h00 && s_axi_araddr[5:4] == 2'h1) begin
        s_axi_rdata <= 32'(mod_q[rd_idx]);
      end else if (s_axi_araddr[11:7] == 5'h00 && s_axi_araddr[5:4] == 2'h2) begin
        s_axi_rdata <= 32'(len_q[rd_idx]);
      end else begin
        s_axi_rresp <= `DAG_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : dag_top
`default_nettype wire

// ==== dv/dag_monitor.sv ====
// Port checks for the dual address generator top.
// Assumes a bind into dag_top and the single core clock.
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checker
// ****
module dag_monitor #(
  parameter int AW = 14
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Requests and addresses
  input wire dag_pkg::dag_req_s data_req_i,
  input wire dag_pkg::dag_req_s dual_req_i,
  input wire logic dual_to_pm_i,
  input wire logic [AW-1:0] data_memory_address_o,
  input wire logic data_memory_address_valid_o,
  input wire logic program_memory_address_valid_o,
  // Extension path
  input wire dag_pkg::dag_pmx_s pmx_i,
  input wire logic [23:0] program_memory_data_bus_o,
  input wire logic [15:0] data_memory_data_bus_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic dm_req;
  logic pm_req;
  // Dual generator on data space counts too
  assign dm_req = data_req_i.valid || (dual_req_i.valid && !dual_to_pm_i);
  assign pm_req = dual_req_i.valid && dual_to_pm_i;
  dm_issue_a: assert property (dm_req |=> data_memory_address_valid_o)
    else $error("data address not issued");
  dm_quiet_a: assert property (!dm_req |=> !data_memory_address_valid_o)
    else $error("spurious data address");
  addr_hold_a: assert property (!dm_req |=> $stable(data_memory_address_o))
    else $error("data address moved without access");
  pm_issue_a: assert property (pm_req |=> program_memory_address_valid_o)
    else $error("program address not issued");
  pm_quiet_a: assert property (!pm_req |=> !program_memory_address_valid_o)
    else $error("spurious program address");
  px_load_a: assert property (pmx_i.rd |=> data_memory_data_bus_o == $past(pmx_i.rdata[23:8]))
    else $error("read upper bits wrong");
  px_store_a: assert property (pmx_i.wr |=> program_memory_data_bus_o[23:8] == $past(pmx_i.wdata))
    else $error("write upper bits wrong");
  px_pair_a: assert property (pmx_i.rd ##1 pmx_i.wr |=> program_memory_data_bus_o[7:0] == $past(pmx_i.rdata[7:0], 2))
    else $error("extension byte lost");
  cover property (data_req_i.valid && pm_req);
  cover property (dual_req_i.valid && !dual_to_pm_i);
  cover property (pmx_i.rd ##1 pmx_i.wr);
endmodule : dag_monitor
bind dag_top dag_monitor #(.AW(AW)) u_dag_monitor (.core_clk_i, .rst_n_i, .data_req_i, .dual_req_i, .dual_to_pm_i,
  .data_memory_address_o, .data_memory_address_valid_o, .program_memory_address_valid_o, .pmx_i,
  .program_memory_data_bus_o, .data_memory_data_bus_o);
`default_nettype wire

// ==== dv/dag_pm_model.sv ====
// Program memory word source for extension reads.
// Assumes one read strobe cycle per data read.
`timescale 1ns/1ns
`default_nettype none
// ****
// Memory model
// ****
module dag_pm_model #(
  parameter logic [23:0] WORD = 24'hABCD12
) (
  // Read strobe
  input wire logic rd_i,
  // Read data
  output logic [23:0] rdata_o
);
  // Released bus shows the inverse, so stale data never matches
  assign rdata_o = rd_i ? WORD : ~WORD;
endmodule : dag_pm_model
`default_nettype wire

// ==== dv/dual_data_address_generators_test.sv ====
// Self-checking bench for the dual address generator top.
// Assumes the package, checker and memory model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module dual_data_address_generators_test;
  // ****
  // Stimulus and wiring
  // ****
  logic core_clk_i = 0, rst_n_i = 0, dual_to_pm_i = 0, pm_rd = 0, pm_wr = 0;
  dag_pkg::dag_req_s data_req_i = '0, dual_req_i = '0;
  dag_pkg::dag_pmx_s pmx_i;
  logic [13:0] data_memory_address_o, program_memory_address_bus_o;
  logic data_memory_address_valid_o, program_memory_address_valid_o;
  logic [23:0] program_memory_data_bus_o, pm_word;
  logic [15:0] data_memory_data_bus_o, pm_wdata = 16'h1234;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  int mismatches = 0, n_compared = 0;
  assign pmx_i = '{pm_wr, pm_rd, pm_wdata, pm_word};
  always #20 core_clk_i = ~core_clk_i;
  dag_top u_dag_top (.*);
  dag_pm_model u_dag_pm_model (.rd_i(pm_rd), .rdata_o(pm_word));
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    // Address and data may be taken at different edges
    fork
      begin
        @(negedge core_clk_i);
        while (!s_axi_awready) @(negedge core_clk_i);
        @(posedge core_clk_i);
        s_axi_awvalid <= 0;
      end
      begin
        @(negedge core_clk_i);
        while (!s_axi_wready) @(negedge core_clk_i);
        @(posedge core_clk_i);
        s_axi_wvalid <= 0;
      end
    join
    @(negedge core_clk_i);
    while (!s_axi_bvalid) @(negedge core_clk_i);
    wr_r = s_axi_bresp;
    @(posedge core_clk_i);
    s_axi_bready <= 0;
  endtask : axw
  task automatic axr(input logic [11:0] a);
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    @(negedge core_clk_i);
    while (!s_axi_arready) @(negedge core_clk_i);
    @(posedge core_clk_i);
    s_axi_arvalid <= 0;
    @(negedge core_clk_i);
    while (!s_axi_rvalid) @(negedge core_clk_i);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    @(posedge core_clk_i);
    s_axi_rready <= 0;
  endtask : axr
  task automatic acc(input logic [4:0] dq, input logic [4:0] uq, input logic pm);
    @(posedge core_clk_i);
    data_req_i <= dq;
    dual_req_i <= uq;
    dual_to_pm_i <= pm;
    @(posedge core_clk_i);
    data_req_i <= '0;
    dual_req_i <= '0;
    @(negedge core_clk_i);
  endtask : acc
  // ****
  // Scenarios
  // ****
  task automatic t_lin;
    axw(12'h004, 32'h10);
    chk(32'(wr_r), 32'h0);
    axw(12'h0F0, 32'h7);
    chk(32'(wr_r), 32'h2);
    axw(12'h018, 32'h3);
    acc(5'h16, 5'h00, 1'b0);
    chk(32'(data_memory_address_valid_o), 32'h1);
    chk(32'(data_memory_address_o), 32'h10);
    acc(5'h16, 5'h00, 1'b0);
    chk(32'(data_memory_address_o), 32'h13);
    axr(12'h004);
    chk(rd_d, 32'h16);
    axr(12'hFFC);
    chk(32'(rd_r), 32'h2);
    $display("test lin done");
  endtask : t_lin
  task automatic t_circ;
    axw(12'h008, 32'h22);
    axw(12'h028, 32'h4);
    axw(12'h01C, 32'h3);
    acc(5'h1B, 5'h00, 1'b0);
    chk(32'(data_memory_address_o), 32'h22);
    axr(12'h008);
    chk(rd_d, 32'h21);
    // Negative step wraps below the buffer base
    axw(12'h014, 32'h3FFF);
    acc(5'h19, 5'h00, 1'b0);
    chk(32'(data_memory_address_o), 32'h21);
    acc(5'h19, 5'h00, 1'b0);
    chk(32'(data_memory_address_o), 32'h20);
    axr(12'h008);
    chk(rd_d, 32'h23);
    $display("test circ done");
  endtask : t_circ
  task automatic t_brev;
    axw(12'h080, 32'h1);
    axw(12'h000, 32'h1);
    acc(5'h12, 5'h00, 1'b0);
    chk(32'(data_memory_address_o), 32'h2000);
    axr(12'h000);
    chk(rd_d, 32'h4);
    $display("test brev done");
  endtask : t_brev
  task automatic t_dual;
    axw(12'h040, 32'h5);
    axw(12'h050, 32'h1);
    // Both generators in one cycle, reversal still on
    acc(5'h12, 5'h10, 1'b1);
    chk(32'(data_memory_address_o), 32'h0800);
    chk(32'(program_memory_address_valid_o), 32'h1);
    chk(32'(program_memory_address_bus_o), 32'h5);
    acc(5'h00, 5'h10, 1'b0);
    chk(32'(data_memory_address_o), 32'h6);
    // First generator keeps the data bus, dual pointer still steps
    acc(5'h12, 5'h10, 1'b0);
    chk(32'(data_memory_address_o), 32'h3800);
    chk(32'(program_memory_address_valid_o), 32'h0);
    axr(12'h040);
    chk(rd_d, 32'h8);
    $display("test dual done");
  endtask : t_dual
  task automatic t_px;
    @(posedge core_clk_i);
    pm_rd <= 1;
    @(posedge core_clk_i);
    pm_rd <= 0;
    pm_wr <= 1;
    @(negedge core_clk_i);
    chk(32'(data_memory_data_bus_o), 32'hABCD);
    @(posedge core_clk_i);
    pm_wr <= 0;
    @(negedge core_clk_i);
    chk(32'(program_memory_data_bus_o), 32'h123412);
    axr(12'h084);
    chk(rd_d, 32'h12);
    $display("test px done");
  endtask : t_px
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1;
    t_lin();
    t_circ();
    t_brev();
    t_dual();
    t_px();
    test_done();
  end
  // Tests need about 90 cycles
  initial begin
    #40000;
    mismatches++;
    test_done();
  end
endmodule : dual_data_address_generators_test
`default_nettype wire
